// >>> shared/sprm_defs.vh
// Constants for the page rights restriction and type change leaf engine
`ifndef SPRM_DEFS_VH
`define SPRM_DEFS_VH
`define SPRM_LEAF_RESTRICT   8'h0e
`define SPRM_LEAF_CHGTYPE    8'h0f
`define SPRM_PARAM_ALIGN_LSB 6
`define SPRM_PAGE_ALIGN_LSB  12
`define SPRM_PARAM_WORDS     16
`define SPRM_FLAG_R          0
`define SPRM_FLAG_W          1
`define SPRM_FLAG_X          2
`define SPRM_FLAG_PEND       3
`define SPRM_FLAG_MOD        4
`define SPRM_FLAG_PR         5
`define SPRM_FLAG_PT_LSB     8
`define SPRM_REGULAR_PAGE_TYPE          8'h02
`define SPRM_PT_TCS          8'h01
`define SPRM_PT_TRIM         8'h04
`define SPRM_RES_OK          8'h00
`define SPRM_RES_LOCKFAIL    8'h0b
`define SPRM_RES_NOTMOD      8'h14
`define SPRM_FLT_NONE        2'h0
`define SPRM_FLT_GP          2'h1
`define SPRM_FLT_PF          2'h2
`define SPRM_FLT_UD          2'h3
`endif

// >>> rtl/sprm_param_fetch.v
// Fetches the 512-bit parameter structure into private scratch storage
`timescale 1ns/1ps
`default_nettype none
module sprm_param_fetch #(
  parameter WORDS = 16
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire        rd_valid,
  input  wire [31:0] rd_data,
  output reg         rd_req,
  output reg  [3:0]  rd_index,
  output reg         done,
  output reg  [511:0] scratch
);
  reg busy;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy     <= 1'b0;
      rd_req   <= 1'b0;
      rd_index <= 4'h0;
      done     <= 1'b0;
      scratch  <= 512'h0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy     <= 1'b1;
        rd_req   <= 1'b1;
        rd_index <= 4'h0;
      end
      else if (busy && rd_valid)
      begin
        scratch[rd_index*32 +: 32] <= rd_data;
        if (rd_index == WORDS - 1)
        begin
          busy   <= 1'b0;
          rd_req <= 1'b0;
          done   <= 1'b1;
        end
        else
          rd_index <= rd_index + 4'h1;
      end
    end
  end
endmodule // sprm_param_fetch
`default_nettype wire

// >>> rtl/sprm_leaf_engine.v
// Leaf engine: restricts page rights and changes page type
`timescale 1ns/1ps
`default_nettype none
`include "sprm_defs.vh"
module sprm_leaf_engine (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        leaf_start,
  input  wire [7:0]  leaf_select_result_reg,
  input  wire [63:0] param_pointer_reg,
  input  wire [63:0] page_pointer_reg,
  input  wire        gen2_present,
  input  wire [1:0]  cpl,
  input  wire        mode64,
  input  wire [31:0] seg_limit,
  output wire        prm_rd_req,
  output wire [3:0]  prm_rd_index,
  input  wire        prm_rd_valid,
  input  wire [31:0] prm_rd_data,
  input  wire        page_in_cache,
  input  wire        page_gen1_busy,
  input  wire        page_gen2_busy,
  input  wire [15:0] meta_rd,
  input  wire        meta_valid,
  input  wire        ecs_initialized,
  input  wire        ecs_locked,
  output reg         meta_we,
  output reg  [15:0] meta_wr,
  output reg         leaf_done,
  output reg  [1:0]  fault_kind,
  output reg  [63:0] fault_addr,
  output reg  [7:0]  result_code,
  output reg         zero_flag,
  output reg         cf,
  output reg         pf,
  output reg         af,
  output reg         of,
  output reg         sf
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_CHECK = 2'd2;

  reg  [1:0]   state;
  reg  [1:0]   next_state;
  reg          fetch_go;
  wire         fetch_done;
  wire [511:0] param_scratch_copy;
  reg  [7:0]   leaf_code;
  reg  [63:0]  pg_ptr;

  sprm_param_fetch #(
    .WORDS (`SPRM_PARAM_WORDS)
  ) u_fetch (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (fetch_go),
    .rd_valid (prm_rd_valid),
    .rd_data  (prm_rd_data),
    .rd_req   (prm_rd_req),
    .rd_index (prm_rd_index),
    .done     (fetch_done),
    .scratch  (param_scratch_copy)
  );

  wire is_restrict = (leaf_code == `SPRM_LEAF_RESTRICT);
  wire is_chgtype  = (leaf_code == `SPRM_LEAF_CHGTYPE);
  wire req_r = param_scratch_copy[`SPRM_FLAG_R];
  wire req_w = param_scratch_copy[`SPRM_FLAG_W];
  wire [7:0] req_pt = param_scratch_copy[`SPRM_FLAG_PT_LSB +: 8];
  // Restriction uses only rwx; type change uses only page type
  wire rsv_nz_rp = (param_scratch_copy[511:3] != 509'h0);
  wire rsv_nz_ct = (param_scratch_copy[7:0] != 8'h00) ||
                   (param_scratch_copy[511:16] != 496'h0);
  wire [7:0] cur_pt = meta_rd[`SPRM_FLAG_PT_LSB +: 8];

  // Rights only narrow: a kept right needs its request bit as well
  wire [2:0] narrowed_rwx;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_rights
      assign narrowed_rwx[gi] =
        meta_rd[`SPRM_FLAG_R + gi] & param_scratch_copy[`SPRM_FLAG_R + gi];
    end
  endgenerate

  function canon;
    input [63:0] a;
    begin
      canon = (a[63:47] == 17'h0) || (a[63:47] == 17'h1ffff);
    end
  endfunction

  // Operand checks that need nothing fetched
  reg [1:0] pre_fault;
  reg [63:0] pre_addr;
  always @*
  begin
    pre_fault = `SPRM_FLT_NONE;
    pre_addr  = 64'h0;
    if (!gen2_present ||
        !(leaf_select_result_reg == `SPRM_LEAF_RESTRICT ||
          leaf_select_result_reg == `SPRM_LEAF_CHGTYPE))
      pre_fault = `SPRM_FLT_UD;
    else if (cpl != 2'd0)
      pre_fault = `SPRM_FLT_GP;
    else if (mode64 && (!canon(param_pointer_reg) ||
             !canon(page_pointer_reg)))
      pre_fault = `SPRM_FLT_GP;
    else if (!mode64 && ((param_pointer_reg[31:0] > seg_limit) ||
             (page_pointer_reg[31:0] > seg_limit)))
      pre_fault = `SPRM_FLT_GP;
    else if (param_pointer_reg[`SPRM_PARAM_ALIGN_LSB-1:0] != 6'h0)
      pre_fault = `SPRM_FLT_GP;
    else if (page_pointer_reg[`SPRM_PAGE_ALIGN_LSB-1:0] != 12'h0)
      pre_fault = `SPRM_FLT_GP;
    else if (!page_in_cache)
    begin
      pre_fault = `SPRM_FLT_PF;
      pre_addr  = page_pointer_reg;
    end
  end

  // Ordered checks on the scratch copy and metadata
  reg [1:0]  chk_fault;
  reg [7:0]  chk_code;
  reg        chk_commit;
  reg [15:0] chk_meta;
  always @*
  begin
    chk_fault  = `SPRM_FLT_NONE;
    chk_code   = `SPRM_RES_OK;
    chk_commit = 1'b0;
    chk_meta   = meta_rd;
    if (is_restrict)
    begin
      if (rsv_nz_rp || (!req_r && req_w))
        chk_fault = `SPRM_FLT_GP;
      else if (page_gen1_busy)
        chk_fault = `SPRM_FLT_GP;
      else if (!meta_valid)
        chk_fault = `SPRM_FLT_PF;
      else if (page_gen2_busy)
        chk_code = `SPRM_RES_LOCKFAIL;
      else if (meta_rd[`SPRM_FLAG_PEND] || meta_rd[`SPRM_FLAG_MOD])
        chk_code = `SPRM_RES_NOTMOD;
      else if (cur_pt != `SPRM_REGULAR_PAGE_TYPE)
        chk_fault = `SPRM_FLT_PF;
      else if (!ecs_initialized)
        chk_fault = `SPRM_FLT_GP;
      else
      begin
        chk_commit = 1'b1;
        chk_meta[`SPRM_FLAG_PR] = 1'b1;
        chk_meta[`SPRM_FLAG_X:`SPRM_FLAG_R] = narrowed_rwx;
      end
    end
    else if (is_chgtype)
    begin
      if (rsv_nz_ct ||
          !(req_pt == `SPRM_PT_TCS || req_pt == `SPRM_PT_TRIM))
        chk_fault = `SPRM_FLT_GP;
      else if (ecs_locked)
        chk_fault = `SPRM_FLT_GP;
      else if (page_gen1_busy)
        chk_code = `SPRM_RES_LOCKFAIL;
      else if (!meta_valid)
        chk_fault = `SPRM_FLT_PF;
      else if (page_gen2_busy)
        chk_code = `SPRM_RES_LOCKFAIL;
      else if (!(cur_pt == `SPRM_REGULAR_PAGE_TYPE ||
               (cur_pt == `SPRM_PT_TCS && req_pt == `SPRM_PT_TRIM)))
        chk_fault = `SPRM_FLT_PF;
      else if (meta_rd[`SPRM_FLAG_PEND] || meta_rd[`SPRM_FLAG_MOD])
        chk_code = `SPRM_RES_NOTMOD;
      else if (!ecs_initialized)
        chk_fault = `SPRM_FLT_GP;
      else
      begin
        chk_commit = 1'b1;
        // Rights dropped and modified set: blocked until accepted
        chk_meta[`SPRM_FLAG_PR]  = 1'b0;
        chk_meta[`SPRM_FLAG_MOD] = 1'b1;
        chk_meta[`SPRM_FLAG_R]   = 1'b0;
        chk_meta[`SPRM_FLAG_W]   = 1'b0;
        chk_meta[`SPRM_FLAG_X]   = 1'b0;
        chk_meta[`SPRM_FLAG_PT_LSB +: 8] = req_pt;
      end
    end
  end

  always @*
  begin
    next_state = state;
    fetch_go   = 1'b0;
    case (state)
      ST_IDLE:
        if (leaf_start && pre_fault == `SPRM_FLT_NONE)
        begin
          fetch_go   = 1'b1;
          next_state = ST_FETCH;
        end
      ST_FETCH:
        if (fetch_done)
          next_state = ST_CHECK;
      ST_CHECK:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state       <= ST_IDLE;
      leaf_code   <= 8'h00;
      pg_ptr      <= 64'h0;
      meta_we     <= 1'b0;
      meta_wr     <= 16'h0;
      leaf_done   <= 1'b0;
      fault_kind  <= `SPRM_FLT_NONE;
      fault_addr  <= 64'h0;
      result_code <= `SPRM_RES_OK;
      zero_flag   <= 1'b0;
      cf          <= 1'b0;
      pf          <= 1'b0;
      af          <= 1'b0;
      of          <= 1'b0;
      sf          <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      meta_we   <= 1'b0;
      leaf_done <= 1'b0;
      if (state == ST_IDLE && leaf_start)
      begin
        // Leaf and page pointer latched so later register changes cannot race the checks
        leaf_code <= leaf_select_result_reg;
        pg_ptr    <= page_pointer_reg;
        if (pre_fault != `SPRM_FLT_NONE)
        begin
          leaf_done  <= 1'b1;
          fault_kind <= pre_fault;
          fault_addr <= pre_addr;
        end
      end
      else if (state == ST_CHECK)
      begin
        leaf_done  <= 1'b1;
        fault_kind <= chk_fault;
        fault_addr <= (chk_fault == `SPRM_FLT_PF) ? pg_ptr : 64'h0;
        if (chk_fault == `SPRM_FLT_NONE)
        begin
          meta_we     <= chk_commit;
          meta_wr     <= chk_meta;
          result_code <= chk_code;
          zero_flag   <= !chk_commit;
          cf          <= 1'b0;
          pf          <= 1'b0;
          af          <= 1'b0;
          of          <= 1'b0;
          sf          <= 1'b0;
        end
      end
    end
  end
endmodule // sprm_leaf_engine
`default_nettype wire

// >>> testbench/sprm_param_mem.sv
// Parameter memory model answering the engine's word fetches
`timescale 1ns/1ps
`default_nettype none
module sprm_param_mem (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rd_req,
  input  wire logic [3:0]  rd_index,
  input  wire logic [31:0] word0,
  input  wire logic        rsvd_bad,
  input  wire logic        slow,
  output logic             rd_valid,
  output logic [31:0]      rd_data
);
  logic wait_q;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      wait_q   <= 1'b0;
      rd_data  <= 32'h0;
    end
    else if (rd_req && !rd_valid && (!slow || wait_q))
    begin
      rd_valid <= 1'b1;
      wait_q   <= 1'b0;
      rd_data  <= (rd_index == 4'h0) ? word0 :
                  {31'h0, rsvd_bad && rd_index == 4'h7};
    end
    else
    begin
      rd_valid <= 1'b0;
      wait_q   <= rd_req && !rd_valid;
      // Data only means something beside valid
      rd_data  <= ~rd_data;
    end
  end
endmodule // sprm_param_mem
`default_nettype wire

// >>> testbench/sprm_leaf_engine_chk.sv
// Port assertions for the leaf engine
`timescale 1ns/1ps
`default_nettype none
`include "sprm_defs.vh"
module sprm_leaf_engine_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        leaf_start,
  input wire logic [7:0]  leaf_select_result_reg,
  input wire logic        gen2_present,
  input wire logic [63:0] param_pointer_reg,
  input wire logic [63:0] page_pointer_reg,
  input wire logic        prm_rd_valid,
  input wire logic [3:0]  prm_rd_index,
  input wire logic [31:0] prm_rd_data,
  input wire logic [15:0] meta_rd,
  input wire logic        meta_we,
  input wire logic [15:0] meta_wr,
  input wire logic        leaf_done,
  input wire logic [1:0]  fault_kind,
  input wire logic [63:0] fault_addr,
  input wire logic [7:0]  result_code,
  input wire logic        zero_flag,
  input wire logic        cf,
  input wire logic        pf,
  input wire logic        af,
  input wire logic        of,
  input wire logic        sf
);
  logic       busy;
  logic [7:0] leaf_q;
  logic [2:0] req_q;
  logic       start_ok;
  logic       ok_done;
  assign start_ok = leaf_start && !busy;
  assign ok_done  = leaf_done && fault_kind == `SPRM_FLT_NONE;
  always @(posedge clk)
  begin
    if (!rst_n)
      busy <= 1'b0;
    else if (leaf_done)
      busy <= 1'b0;
    else if (leaf_start)
      busy <= 1'b1;
    if (start_ok)
      leaf_q <= leaf_select_result_reg;
    if (prm_rd_valid && prm_rd_index == 4'h0)
      req_q <= prm_rd_data[2:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_BAD_LEAF: assert property (start_ok &&
    leaf_select_result_reg != `SPRM_LEAF_RESTRICT &&
    leaf_select_result_reg != `SPRM_LEAF_CHGTYPE
    |=> leaf_done && fault_kind == `SPRM_FLT_UD) else $error("bad leaf");
  AST_PARAM_ALIGN: assert property (start_ok && gen2_present &&
    leaf_select_result_reg == `SPRM_LEAF_RESTRICT &&
    param_pointer_reg[5:0] != 6'h0
    |=> leaf_done && fault_kind != `SPRM_FLT_NONE) else $error("align");
  AST_LAST_WORD: assert property (
    prm_rd_valid && prm_rd_index == 4'hf |-> ##3 leaf_done)
    else $error("late done");
  AST_PF_ADDR: assert property (
    leaf_done && fault_kind == `SPRM_FLT_PF |-> fault_addr == page_pointer_reg)
    else $error("fault address");
  AST_FA_ZERO: assert property (
    leaf_done && fault_kind != `SPRM_FLT_PF |-> fault_addr == 64'h0)
    else $error("fault address not zero");
  AST_PR_SET: assert property (
    meta_we && leaf_q == `SPRM_LEAF_RESTRICT
    |-> meta_wr[5] && meta_wr[15:8] == `SPRM_REGULAR_PAGE_TYPE) else $error("pr bit");
  AST_RIGHTS: assert property (
    meta_we && leaf_q == `SPRM_LEAF_RESTRICT
    |-> meta_wr[2:0] == (meta_rd[2:0] & req_q)) else $error("rights");
  AST_ZF_CODE: assert property (
    ok_done |-> zero_flag == (result_code != `SPRM_RES_OK))
    else $error("zero flag");
  AST_FLAGS: assert property (
    ok_done |-> !(cf || pf || af || of || sf)) else $error("flags");
  AST_NO_META: assert property (
    meta_we |-> leaf_done && fault_kind == `SPRM_FLT_NONE &&
    result_code == `SPRM_RES_OK ##1 !meta_we) else $error("meta write");
  cover property (meta_we);
  cover property (leaf_done && result_code == `SPRM_RES_LOCKFAIL);
  cover property (leaf_done && fault_kind == `SPRM_FLT_PF);
endmodule // sprm_leaf_engine_chk
bind sprm_leaf_engine sprm_leaf_engine_chk u_sprm_leaf_engine_chk (.*);
`default_nettype wire

// >>> testbench/tb_sprm_leaf_engine.sv
// Self-checking bench for the leaf engine
`timescale 1ns/1ps
`default_nettype none
`include "sprm_defs.vh"
module tb_sprm_leaf_engine;
  localparam logic [7:0]  R = `SPRM_LEAF_RESTRICT;
  localparam logic [7:0]  T = `SPRM_LEAF_CHGTYPE;
  localparam logic [7:0]  G = 8'he6;
  localparam logic [63:0] P = 64'h40;
  localparam logic [63:0] A = 64'h1000;
  localparam logic [15:0] M = 16'h0207;
  logic clk = 1'b0, rst_n = 1'b0, leaf_start = 1'b0, bad = 1'b0;
  logic slow = 1'b0, gen2_present = 1'b0, mode64 = 1'b0;
  logic page_in_cache = 1'b0, page_gen1_busy = 1'b0, page_gen2_busy = 1'b0;
  logic meta_valid = 1'b0, ecs_initialized = 1'b0, ecs_locked = 1'b0;
  logic [1:0]  cpl = 2'h0;
  logic [7:0]  leaf_select_result_reg = 8'h0, lr = 8'h0;
  logic [63:0] param_pointer_reg = 64'h0, page_pointer_reg = 64'h0;
  logic [31:0] seg_limit = 32'hffffffff, w0 = 32'h0;
  logic [15:0] meta_rd = 16'h0;
  logic        prm_rd_req, prm_rd_valid, meta_we, leaf_done, zero_flag, lz;
  logic        cf, pf, af, of, sf;
  logic [3:0]  prm_rd_index;
  logic [31:0] prm_rd_data;
  logic [15:0] meta_wr;
  logic [1:0]  fault_kind;
  logic [63:0] fault_addr;
  logic [7:0]  result_code;
  logic [32:0] expq[$];
  logic [31:0] r;
  int          errors = 0, cmp_count = 0, cyc = 0;
  always #4 clk = ~clk;
  sprm_leaf_engine u_sprm_leaf_engine (.*);
  sprm_param_mem u_sprm_param_mem (.clk(clk), .rst_n(rst_n),
    .rd_req(prm_rd_req), .rd_index(prm_rd_index), .word0(w0),
    .rsvd_bad(bad), .slow(slow), .rd_valid(prm_rd_valid),
    .rd_data(prm_rd_data));
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Expected write is built from the rules, not from the outputs
  task automatic run(input logic [7:0] s, input logic [63:0] pa, pg,
    input logic [15:0] m, input logic [31:0] w, input logic [7:0] e,
    input logic [1:0] ef, input logic [7:0] er);
    logic [15:0] wr;
    logic        we;
    we = ef == `SPRM_FLT_NONE && er == `SPRM_RES_OK;
    if (s == R)
      wr = {m[15:6], 1'b1, m[4:3], m[2:0] & w[2:0]};
    else
      wr = {w[15:8], m[7:6], 2'b01, m[3], 3'h0};
    if (ef == `SPRM_FLT_NONE)
    begin
      lr = er;
      lz = er != `SPRM_RES_OK;
    end
    expq.push_back({ef, lr, lz, we, we ? wr : 16'h0, 5'h0});
    @(posedge clk);
    leaf_select_result_reg <= s;
    param_pointer_reg <= pa;
    page_pointer_reg <= pg;
    meta_rd <= m;
    w0 <= w;
    {mode64, gen2_present, page_in_cache, page_gen1_busy, page_gen2_busy,
     meta_valid, ecs_initialized, ecs_locked} <= e;
    leaf_start <= 1'b1;
    @(posedge clk);
    leaf_start <= 1'b0;
    while (expq.size() != 0)
      @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      conclude;
    end
    if (rst_n && leaf_done === 1'b1)
    begin
      if (expq.size() == 0)
        check(33'h0, 33'h1);
      else
        check({fault_kind, result_code, zero_flag, meta_we,
               meta_we ? meta_wr : 16'h0, cf, pf, af, of, sf},
              expq.pop_front());
    end
  end
  initial
  begin
    void'($urandom(32'h01f0));
    lz = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    run(8'h05, P, A, M, 7, G, `SPRM_FLT_UD, 0);
    run(R, P, A, M, 7, G & 8'hbf, `SPRM_FLT_UD, 0);
    run(R, 64'h48, A, M, 7, G, `SPRM_FLT_GP, 0);
    run(R, P, 64'h1800, M, 7, G, `SPRM_FLT_GP, 0);
    run(R, P, A, M, 7, G & 8'hdf, `SPRM_FLT_PF, 0);
    run(R, P, A, M, 2, G, `SPRM_FLT_GP, 0);
    bad <= 1'b1;
    run(R, P, A, M, 7, G, `SPRM_FLT_GP, 0);
    bad <= 1'b0;
    run(R, P, A, M, 7, G | 8'h10, `SPRM_FLT_GP, 0);
    run(R, P, A, M, 7, G & 8'hfb, `SPRM_FLT_PF, 0);
    run(R, P, A, M, 7, G | 8'h08, 0, `SPRM_RES_LOCKFAIL);
    run(R, P, A, M, 7, 8'hea, `SPRM_FLT_PF, 0);
    run(R, P, A, 16'h020f, 7, G, 0, `SPRM_RES_NOTMOD);
    run(R, P, A, 16'h0217, 7, G, 0, `SPRM_RES_NOTMOD);
    // Mid-run reset: result and zero flag must return to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    lr = 8'h0;
    lz = 1'b0;
    run(R, P, A, 16'h0107, 7, G, `SPRM_FLT_PF, 0);
    run(R, P, A, M, 7, G & 8'hfd, `SPRM_FLT_GP, 0);
    seg_limit <= 32'hfff;
    run(R, P, A, M, 7, G & 8'h7f, `SPRM_FLT_GP, 0);
    seg_limit <= 32'hffffffff;
    run(R, P, 64'h800000000000, M, 7, G, `SPRM_FLT_GP, 0);
    run(`SPRM_LEAF_CHGTYPE, P, A, M, 32'h400, G, 0, 0);
    run(T, P, A, M, 32'h400, G | 8'h01, `SPRM_FLT_GP, 0);
    run(T, P, A, M, 32'h400, G | 8'h10, 0, `SPRM_RES_LOCKFAIL);
    run(T, P, A, M, 32'h300, G, `SPRM_FLT_GP, 0);
    cpl <= 2'h1;
    run(T, P, A, M, 32'h400, G, `SPRM_FLT_GP, 0);
    cpl <= 2'h0;
    run(R, P, A, M, 7, G, 0, 0);
    repeat (8)
    begin
      r = $urandom;
      slow <= r[6];
      run(R, P, A, {8'h02, 5'h0, r[5:3]},
          {29'h0, r[2], r[1], r[0] | r[1]}, G, 0, 0);
    end
    conclude;
  end
endmodule // tb_sprm_leaf_engine
`default_nettype wire
